// file: core/dmr_pkg.sv
// constants, field positions and carrier types for the drive register bank
package dmr_pkg;

  // ----------------------------------------
  // register addresses
  // ----------------------------------------
  localparam logic [15:0] DMR_ADR_CMD_RSVD  = 16'h2400;
  localparam logic [15:0] DMR_ADR_OP_CMD    = 16'h2401;
  localparam logic [15:0] DMR_ADR_FREQ_REF  = 16'h2402;
  localparam logic [15:0] DMR_ADR_MON_RSVD  = 16'h2420;
  localparam logic [15:0] DMR_ADR_OP_STAT   = 16'h2421;
  localparam logic [15:0] DMR_ADR_FREQ_MON  = 16'h2422;
  localparam logic [15:0] DMR_ADR_OUT_FREQ  = 16'h2423;
  localparam logic [15:0] DMR_ADR_OUT_CURR  = 16'h2424;
  localparam logic [15:0] DMR_ADR_OUT_VOLT  = 16'h2425;
  localparam logic [15:0] DMR_ADR_DC_VOLT   = 16'h2426;
  localparam logic [15:0] DMR_ADR_ALARM     = 16'h2427;
  localparam logic [15:0] DMR_ADR_FAULT     = 16'h2428;
  localparam logic [15:0] DMR_ADR_TERM_IO   = 16'h2429;
  localparam logic [15:0] DMR_ADR_AI_ONE    = 16'h242A;
  localparam logic [15:0] DMR_ADR_COMM_B    = 16'h242B;
  localparam logic [15:0] DMR_ADR_MON_RSVDC = 16'h242C;
  localparam logic [15:0] DMR_ADR_AO_ONE    = 16'h242D;
  localparam logic [15:0] DMR_ADR_COMM_E    = 16'h242E;

  // ----------------------------------------
  // reset values, field positions, answers
  // ----------------------------------------
  localparam logic [15:0] DMR_RST_WORD      = 16'h0000;
  localparam int          DMR_OPC_RUN       = 0;
  localparam int          DMR_OPC_REV       = 1;
  localparam int          DMR_OPC_EXT_FAULT = 2;
  localparam int          DMR_OPC_FLT_RESET = 3;
  localparam int          DMR_OPC_VTERM_LO  = 8;
  localparam int          DMR_TIO_RELAY_ONE = 12;
  localparam int          DMR_NUM_TERM      = 6;
  localparam logic [7:0]  DMR_EXC_NONE      = 8'h00;
  localparam logic [7:0]  DMR_EXC_ADDR      = 8'h02;

  // ----------------------------------------
  // alarm codes
  // ----------------------------------------
  localparam logic [15:0] DMR_ALM_NONE       = 16'h0000;
  localparam logic [15:0] DMR_ALM_COMM_FAULT = 16'h0001;
  localparam logic [15:0] DMR_ALM_EXT_FAULT  = 16'h0002;
  localparam logic [15:0] DMR_ALM_PID_HIGH   = 16'h0012;
  localparam logic [15:0] DMR_ALM_PID_LOW    = 16'h0013;
  localparam logic [15:0] DMR_ALM_OVERTORQUE = 16'h0016;
  localparam logic [15:0] DMR_ALM_OVERVOLT   = 16'h0018;
  localparam logic [15:0] DMR_ALM_UNDERVOLT  = 16'h0019;
  localparam logic [15:0] DMR_ALM_BASEBLOCK  = 16'h001F;
  localparam logic [15:0] DMR_ALM_HEAT_WARN  = 16'h0020;
  localparam logic [15:0] DMR_ALM_COMM_ERROR = 16'h0024;

  // ----------------------------------------
  // carrier types
  // ----------------------------------------
  typedef struct packed {
    logic        running;
    logic        reversing;
    logic        zero_speed;
    logic        speed_agree;
    logic        ready;
    logic        freq_from_comm;
    logic        run_from_comm;
    logic        relay_one;
    logic [15:0] freq_ref;
    logic [15:0] out_freq;
    logic [15:0] out_current;
    logic [15:0] out_voltage;
    logic [15:0] dc_bus_voltage;
    logic [15:0] analog_input_one;
    logic [15:0] analog_output_one;
    logic [15:0] comm_word_b;
    logic [15:0] comm_word_e;
  } dmr_mon_t;

  typedef struct packed {
    logic ext_fault_one;
    logic pid_fb_high;
    logic pid_fb_low;
    logic overtorque_detect_one;
    logic overvoltage;
    logic undervoltage;
    logic baseblock;
    logic heatsink_overheat_warning;
    logic modbus_comm_error;
  } dmr_alarm_t;

  typedef struct packed {
    logic       run;
    logic       reverse;
    logic       comm_external_fault;
    logic       fault_reset;
    logic [7:0] vterm;
    logic [15:0] freq_ref;
  } dmr_cmd_t;

endpackage

// file: core/dmr_regbank.sv
// drive serial-bus register bank: command words, monitor words, range check
//
// Operation
// [R1] command group at 2401h and 2402h is readable and writable by the master
// [R2] command bit0 run, bit1 reverse, bit2 external fault, bit3 fault reset
// [R3] command bits 8 to 15 drive eight virtual multi-function input terminals
// [R4] frequency reference is an unsigned count of 0.01 Hz steps
// [R5] monitor group from 2420h is read-only; writes leave reported values alone
// [R6] status bits 0..6: run, reverse, zero speed, fault, alarm, agree, ready
// [R7] status bit7 frequency from link, bit8 run command from link
// [R8] active reference and output frequency in consecutive words, 0.01 Hz steps
// [R9] output current word in 0.1 A steps
// [R10] output voltage word in 0.1 V steps
// [R11] dc bus voltage word in 0.1 V steps
// [R12] terminal word: bits 0..5 physical inputs, bit12 relay one
// [R13] analog input one: 0 is zero, 1000 is full scale
// [R14] analog output one: 0 is zero volts, 1000 is ten volts
// [R15] alarm word 0 when clear, heatsink overheat warning is code 32
// [R16] overtorque is code 22; other alarms have their own codes
// [R17] fault word 0 when no fault latched, else the fault code
// [R18] every register is sixteen bits, one word per access
// [R19] access outside the supported range answers exception code 2
`timescale 1ns/1ns
module dmr_regbank
  import dmr_pkg::*;
(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             nrst,
  // register access
  input  wire logic             req,
  input  wire logic             wr,
  input  wire logic [15:0]      addr,
  input  wire logic [15:0]      wdata,
  output logic                  ack,
  output logic [15:0]           rdata,
  output logic                  exc,
  output logic [7:0]            exc_code,
  // drive core state
  input  wire dmr_mon_t         mon,
  input  wire dmr_alarm_t       alarms,
  input  wire logic             fault_active,
  input  wire logic [15:0]      fault_code_in,
  // physical terminals, asynchronous
  input  wire logic [5:0]       term_in,
  // command outputs
  output dmr_cmd_t              cmd,
  output logic                  fault_reset_pulse
);

  // ----------------------------------------
  // functions
  // ----------------------------------------
  function automatic logic addr_ok(input logic [15:0] a);
    addr_ok = (a >= DMR_ADR_CMD_RSVD && a <= DMR_ADR_FREQ_REF) ||
              (a >= DMR_ADR_MON_RSVD && a <= DMR_ADR_COMM_E);
  endfunction

  function automatic logic [15:0] alarm_encode(input dmr_alarm_t al, input logic comm_fault);
    alarm_encode = DMR_ALM_NONE;
    if (comm_fault)                        alarm_encode = DMR_ALM_COMM_FAULT;
    else if (al.ext_fault_one)             alarm_encode = DMR_ALM_EXT_FAULT;
    else if (al.overtorque_detect_one)     alarm_encode = DMR_ALM_OVERTORQUE;
    else if (al.overvoltage)               alarm_encode = DMR_ALM_OVERVOLT;
    else if (al.undervoltage)              alarm_encode = DMR_ALM_UNDERVOLT;
    else if (al.heatsink_overheat_warning) alarm_encode = DMR_ALM_HEAT_WARN;
    else if (al.pid_fb_high)               alarm_encode = DMR_ALM_PID_HIGH;
    else if (al.pid_fb_low)                alarm_encode = DMR_ALM_PID_LOW;
    else if (al.baseblock)                 alarm_encode = DMR_ALM_BASEBLOCK;
    else if (al.modbus_comm_error)         alarm_encode = DMR_ALM_COMM_ERROR;
  endfunction

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic [1:0] rst_sync_q;
  logic       rst_n;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // ----------------------------------------
  // terminal input filter
  // ----------------------------------------
  wire logic [5:0] term_q;

  genvar gi;
  generate
    for (gi = 0; gi < DMR_NUM_TERM; gi++) begin : g_term
      logic [2:0] sync_q;
      logic       filt_q;
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          sync_q <= 3'b000;
        end else begin
          sync_q <= {sync_q[1:0], term_in[gi]};
        end
      end
      // change taken once stages two and three agree
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          filt_q <= 1'b0;
        end else if (sync_q[1] == sync_q[2]) begin
          filt_q <= sync_q[2];  // [R12]
        end
      end
      // one driver per bit of the filtered word
      assign term_q[gi] = filt_q;
    end
  endgenerate

  // ----------------------------------------
  // bus answer state
  // ----------------------------------------
  typedef enum logic [1:0] {
    DMR_ST_IDLE = 2'b01,
    DMR_ST_ANS  = 2'b10
  } dmr_state_t;

  dmr_state_t state_q;
  logic       hit_wr_op;
  logic       hit_wr_freq;

  assign hit_wr_op   = req && wr && addr == DMR_ADR_OP_CMD;  // [R5]
  assign hit_wr_freq = req && wr && addr == DMR_ADR_FREQ_REF;  // [R5]

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= DMR_ST_IDLE;
    end else begin
      case (state_q)
        DMR_ST_IDLE: state_q <= req ? DMR_ST_ANS : DMR_ST_IDLE;
        DMR_ST_ANS:  state_q <= req ? DMR_ST_ANS : DMR_ST_IDLE;
        default:     state_q <= DMR_ST_IDLE;
      endcase
    end
  end
  assign ack = state_q == DMR_ST_ANS;

  // ----------------------------------------
  // command registers
  // ----------------------------------------
  logic [15:0] op_cmd_q;
  logic [15:0] freq_ref_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      op_cmd_q <= DMR_RST_WORD;
    end else if (hit_wr_op && addr_ok(addr)) begin
      op_cmd_q <= wdata;  // [R1] [R2] [R3]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      freq_ref_q <= DMR_RST_WORD;
    end else if (hit_wr_freq) begin
      freq_ref_q <= wdata;  // [R1] [R4]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_reset_pulse <= 1'b0;
    end else begin
      fault_reset_pulse <= hit_wr_op && wdata[DMR_OPC_FLT_RESET];  // [R2]
    end
  end

  assign cmd.run                 = op_cmd_q[DMR_OPC_RUN];
  assign cmd.reverse             = op_cmd_q[DMR_OPC_REV];
  assign cmd.comm_external_fault = op_cmd_q[DMR_OPC_EXT_FAULT];
  assign cmd.fault_reset         = op_cmd_q[DMR_OPC_FLT_RESET];
  assign cmd.vterm               = op_cmd_q[15:DMR_OPC_VTERM_LO];  // [R3]
  assign cmd.freq_ref            = freq_ref_q;

  // ----------------------------------------
  // alarm and fault words
  // ----------------------------------------
  logic [15:0] alarm_q;
  logic        fault_q;
  logic [15:0] fault_code_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      alarm_q <= DMR_ALM_NONE;
    end else begin
      alarm_q <= alarm_encode(alarms, op_cmd_q[DMR_OPC_EXT_FAULT]);  // [R15] [R16]
    end
  end

  // new fault wins over a reset in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_q      <= 1'b0;
      fault_code_q <= DMR_RST_WORD;
    end else if (fault_active) begin
      fault_q      <= 1'b1;
      fault_code_q <= fault_code_in;  // [R17]
    end else if (fault_reset_pulse) begin
      fault_q      <= 1'b0;
      fault_code_q <= DMR_RST_WORD;  // [R17]
    end
  end

  // ----------------------------------------
  // monitor words
  // ----------------------------------------
  logic [15:0] status_w;
  logic [15:0] term_io_w;

  always_comb begin
    status_w     = DMR_RST_WORD;
    status_w[0]  = mon.running;  // [R6]
    status_w[1]  = mon.reversing;
    status_w[2]  = mon.zero_speed;
    status_w[3]  = fault_q;
    status_w[4]  = alarm_q != DMR_ALM_NONE;
    status_w[5]  = mon.speed_agree;
    status_w[6]  = mon.ready;
    status_w[7]  = mon.freq_from_comm;  // [R7]
    status_w[8]  = mon.run_from_comm;  // [R7]
  end

  always_comb begin
    term_io_w                    = DMR_RST_WORD;
    term_io_w[5:0]               = term_q;  // [R12]
    term_io_w[DMR_TIO_RELAY_ONE] = mon.relay_one;
  end

  // ----------------------------------------
  // read answer
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata    <= DMR_RST_WORD;
      exc      <= 1'b0;
      exc_code <= DMR_EXC_NONE;
    end else if (req) begin
      exc      <= !addr_ok(addr);  // [R19]
      exc_code <= addr_ok(addr) ? DMR_EXC_NONE : DMR_EXC_ADDR;
      case (addr)  // [R18]
        DMR_ADR_OP_CMD:   rdata <= op_cmd_q;
        DMR_ADR_FREQ_REF: rdata <= freq_ref_q;
        DMR_ADR_OP_STAT:  rdata <= status_w;
        DMR_ADR_FREQ_MON: rdata <= mon.freq_ref;  // [R8]
        DMR_ADR_OUT_FREQ: rdata <= mon.out_freq;  // [R8]
        DMR_ADR_OUT_CURR: rdata <= mon.out_current;  // [R9]
        DMR_ADR_OUT_VOLT: rdata <= mon.out_voltage;  // [R10]
        DMR_ADR_DC_VOLT:  rdata <= mon.dc_bus_voltage;  // [R11]
        DMR_ADR_ALARM:    rdata <= alarm_q;
        DMR_ADR_FAULT:    rdata <= fault_code_q;
        DMR_ADR_TERM_IO:  rdata <= term_io_w;
        DMR_ADR_AI_ONE:   rdata <= mon.analog_input_one;  // [R13]
        DMR_ADR_COMM_B:   rdata <= mon.comm_word_b;
        DMR_ADR_AO_ONE:   rdata <= mon.analog_output_one;  // [R14]
        DMR_ADR_COMM_E:   rdata <= mon.comm_word_e;
        default:          rdata <= DMR_RST_WORD;
      endcase
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_OPCMD_WRITE: assert property ( // [R1]
    hit_wr_op |=> op_cmd_q == $past(wdata))
    else $error("operation command not stored");

  AST_FREQ_WRITE: assert property ( // [R4]
    hit_wr_freq |=> cmd.freq_ref == $past(wdata))
    else $error("frequency reference not stored");

  AST_VTERM_MAP: assert property ( // [R3]
    hit_wr_op |=> cmd.vterm == $past(wdata[15:8]) && cmd.run == $past(wdata[0]))
    else $error("virtual terminals do not follow command bits");

  AST_RO_WRITE: assert property ( // [R5]
    req && wr && addr >= DMR_ADR_MON_RSVD |=> $stable(op_cmd_q) && $stable(freq_ref_q))
    else $error("monitor write changed a command word");

  AST_STATUS_READ: assert property ( // [R6]
    req && !wr && addr == DMR_ADR_OP_STAT && mon.running && mon.ready
      |=> ack && rdata[0] && rdata[6] && rdata[15:9] == 7'h00)
    else $error("status word does not reflect run and ready");

  AST_ALARM_OT: assert property ( // [R16]
    alarms == dmr_alarm_t'(9'h020) && !op_cmd_q[2] |=> alarm_q == DMR_ALM_OVERTORQUE)
    else $error("overtorque alarm code wrong");

  AST_ALARM_HEAT: assert property ( // [R15]
    alarms == dmr_alarm_t'(9'h002) && !op_cmd_q[2] |=> alarm_q == DMR_ALM_HEAT_WARN)
    else $error("heatsink warning alarm code wrong");

  AST_FAULT_CLEAR: assert property ( // [R17]
    !fault_q |-> fault_code_q == DMR_RST_WORD)
    else $error("fault code nonzero without fault");

  AST_FAULT_HOLD: assert property ( // [R17]
    fault_active ##1 !fault_active && !fault_reset_pulse |=> fault_q)
    else $error("fault latch lost without reset");

  AST_EXC_RANGE: assert property ( // [R19]
    req && !addr_ok(addr) |=> ack && exc && exc_code == DMR_EXC_ADDR)
    else $error("out of range access not refused");

  AST_ACK_ONE: assert property ( // [R18]
    req ##1 !req |=> !ack)
    else $error("answer lasted more than one cycle");

  AST_FAULT_SET_WINS: assert property ( // [R17]
    fault_active |=> fault_q && fault_code_q == $past(fault_code_in))
    else $error("fault latch did not take the present fault");

  AST_RESET_PULSE: assert property ( // [R2]
    fault_reset_pulse |-> $past(req && wr && addr == DMR_ADR_OP_CMD && wdata[DMR_OPC_FLT_RESET]))
    else $error("fault reset pulse without a reset command");

  AST_RSVD_ZERO: assert property ( // [R18]
    req && (addr == DMR_ADR_CMD_RSVD || addr == DMR_ADR_MON_RSVD || addr == DMR_ADR_MON_RSVDC)
      |=> rdata == DMR_RST_WORD && !exc)
    else $error("reserved word did not read as zero");

  COV_WRITE_RUN:   cover property (hit_wr_op && wdata[0] ##1 cmd.run);
  COV_READ_STATUS: cover property (req && !wr && addr == DMR_ADR_OP_STAT ##1 ack);
  COV_EXCEPTION:   cover property (ack && exc);
  COV_FAULT_RESET: cover property (fault_q ##1 fault_reset_pulse ##1 !fault_q);
  COV_SET_WINS:    cover property (fault_active && fault_reset_pulse ##1 fault_q);

endmodule

// file: test/dmr_master_model.sv
// bus master model: single-word register reads and writes
`timescale 1ns/1ns
module dmr_master_model
  import dmr_pkg::*;
(
  // clock
  input  wire logic        clk,
  // register access
  output logic             req,
  output logic             wr,
  output logic [15:0]      addr,
  output logic [15:0]      wdata,
  input  wire logic        ack,
  input  wire logic [15:0] rdata,
  input  wire logic        exc,
  input  wire logic [7:0]  exc_code
);
  initial begin
    req   = 1'b0;
    wr    = 1'b0;
    addr  = 16'h0000;
    wdata = 16'hffff;
  end

  // one request pulse, answer taken a cycle later; released lines show inverse
  task automatic access(input logic w, input logic [15:0] a, input logic [15:0] d,
                        output logic k, output logic [15:0] q, output logic e, output logic [7:0] c);
    @(negedge clk);
    req   = 1'b1;
    wr    = w;
    addr  = a;
    wdata = d; // whole word, pre-scaled count
    @(negedge clk);
    req   = 1'b0;
    addr  = ~a;
    wdata = ~d;
    k     = ack;
    q     = rdata;
    e     = exc;
    c     = exc_code;
  endtask
endmodule

// file: test/dmr_regbank_tb.sv
// self-checking bench for the drive register bank
`timescale 1ns/1ns
module dmr_regbank_tb import dmr_pkg::*; ;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        req, wr, ack, exc, fault_active, fault_reset_pulse, k, e;
  logic [15:0] addr, wdata, rdata, fault_code_in, q, w;
  logic [7:0]  exc_code, c;
  logic [5:0]  term_in;
  dmr_mon_t    mon;
  dmr_alarm_t  alarms;
  dmr_cmd_t    cmd;
  int          miscompares = 0;
  int          compares = 0;
  logic [15:0] mon_adr [11] = '{16'h2420, 16'h2422, 16'h2423, 16'h2424, 16'h2425, 16'h2426,
                                16'h242a, 16'h242b, 16'h242c, 16'h242d, 16'h242e};
  logic [15:0] mon_exp [11] = '{16'h0000, 16'h1770, 16'h1388, 16'h0123, 16'h0dc0, 16'h0c80,
                                16'h03e8, 16'h5a5a, 16'h0000, 16'h01f4, 16'ha5c3};
  logic [15:0] alm_exp [9] = '{16'h0002, 16'h0012, 16'h0013, 16'h0016, 16'h0018, 16'h0019,
                               16'h001f, 16'h0020, 16'h0024};

  always #50 clk = ~clk;

  dmr_regbank u_dmr_regbank (.clk(clk), .nrst(nrst), .req(req), .wr(wr), .addr(addr), .wdata(wdata),
    .ack(ack), .rdata(rdata), .exc(exc), .exc_code(exc_code), .mon(mon), .alarms(alarms),
    .fault_active(fault_active), .fault_code_in(fault_code_in), .term_in(term_in), .cmd(cmd),
    .fault_reset_pulse(fault_reset_pulse));

  dmr_master_model u_dmr_master_model (.clk(clk), .req(req), .wr(wr), .addr(addr), .wdata(wdata),
    .ack(ack), .rdata(rdata), .exc(exc), .exc_code(exc_code));

  // ----------------------------------------
  // checking and access helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
    u_dmr_master_model.access(1'b1, a, d, k, q, e, c);
    chk({k, e, c}, {1'b1, 1'b0, DMR_EXC_NONE});
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [15:0] x);
    u_dmr_master_model.access(1'b0, a, 16'h0000, k, q, e, c);
    chk({k, e, c, q}, {1'b1, 1'b0, DMR_EXC_NONE, x});
  endtask

  task automatic bad(input logic wv, input logic [15:0] a);
    u_dmr_master_model.access(wv, a, 16'hbeef, k, q, e, c);
    chk({k, e, c, q}, {1'b1, 1'b1, DMR_EXC_ADDR, 16'h0000});
  endtask

  task automatic finish_test;
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    #2000000;
    miscompares++;
    finish_test();
  end

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    mon = '0;
    alarms = '0;
    fault_active = 1'b0;
    fault_code_in = 16'h0000;
    term_in = 6'h00;
    repeat (16) @(negedge clk);
    nrst = 1'b1;
    repeat (3) @(negedge clk);
    chk(cmd, '0);
    rd_chk(DMR_ADR_OP_CMD, 16'h0000);
    rd_chk(DMR_ADR_FREQ_REF, 16'h0000);
    $display("test reset done");
    for (int i = 0; i < 16; i++) begin
      if (i > 3 && i < 8) continue;
      w = 16'h0001 << i;
      wr_reg(DMR_ADR_OP_CMD, w);
      chk(fault_reset_pulse, w[3]);
      chk({cmd.vterm, cmd.fault_reset, cmd.comm_external_fault, cmd.reverse, cmd.run}, {w[15:8], w[3:0]});
      rd_chk(DMR_ADR_OP_CMD, w);
    end
    repeat (2) @(negedge clk);
    rd_chk(DMR_ADR_ALARM, 16'h0000);
    wr_reg(DMR_ADR_OP_CMD, 16'h0004);
    repeat (2) @(negedge clk);
    rd_chk(DMR_ADR_ALARM, 16'h0001);
    wr_reg(DMR_ADR_OP_CMD, 16'h0000);
    $display("test command done");
    for (int i = 0; i < 2; i++) begin
      w = i ? 16'h0001 : 16'hffff;
      wr_reg(DMR_ADR_FREQ_REF, w);
      chk(cmd.freq_ref, w);
      rd_chk(DMR_ADR_FREQ_REF, w);
    end
    $display("test frequency done");
    mon.freq_ref = 16'h1770;
    mon.out_freq = 16'h1388;
    mon.out_current = 16'h0123;
    mon.out_voltage = 16'h0dc0;
    mon.dc_bus_voltage = 16'h0c80;
    mon.analog_input_one = 16'h03e8;
    mon.comm_word_b = 16'h5a5a;
    mon.analog_output_one = 16'h01f4;
    mon.comm_word_e = 16'ha5c3;
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 11; i++) rd_chk(mon_adr[i], mon_exp[i]);
      for (int a = 16'h2420; a <= 16'h242e; a++) wr_reg(a[15:0], 16'hffff);
    end
    $display("test monitor done");
    {mon.running, mon.reversing, mon.zero_speed, mon.speed_agree, mon.ready, mon.freq_from_comm,
     mon.run_from_comm} = 7'b1010101;
    rd_chk(DMR_ADR_OP_STAT, 16'h0145);
    {mon.running, mon.reversing, mon.zero_speed, mon.speed_agree, mon.ready, mon.freq_from_comm,
     mon.run_from_comm} = 7'b0101010;
    rd_chk(DMR_ADR_OP_STAT, 16'h00a2);
    mon = '0;
    for (int i = 0; i < 9; i++) begin
      alarms = dmr_alarm_t'(9'h100 >> i);
      repeat (2) @(negedge clk);
      rd_chk(DMR_ADR_ALARM, alm_exp[i]);
      rd_chk(DMR_ADR_OP_STAT, 16'h0010);
    end
    alarms = '0;
    $display("test alarm done");
    fault_active = 1'b1;
    fault_code_in = 16'h0021;
    repeat (2) @(negedge clk);
    rd_chk(DMR_ADR_FAULT, 16'h0021);
    rd_chk(DMR_ADR_OP_STAT, 16'h0008);
    fault_active = 1'b0;
    rd_chk(DMR_ADR_FAULT, 16'h0021);
    wr_reg(DMR_ADR_OP_CMD, 16'h0008);
    chk(fault_reset_pulse, 1'b1);
    repeat (2) @(negedge clk);
    rd_chk(DMR_ADR_FAULT, 16'h0000);
    fault_active = 1'b1;
    fault_code_in = 16'h0033;
    wr_reg(DMR_ADR_OP_CMD, 16'h0008);
    repeat (2) @(negedge clk);
    rd_chk(DMR_ADR_FAULT, 16'h0033);
    fault_active = 1'b0;
    wr_reg(DMR_ADR_OP_CMD, 16'h0008);
    repeat (2) @(negedge clk);
    rd_chk(DMR_ADR_FAULT, 16'h0000);
    $display("test fault done");
    term_in = 6'h2a;
    mon.relay_one = 1'b1;
    repeat (6) @(negedge clk);
    rd_chk(DMR_ADR_TERM_IO, 16'h102a);
    term_in = 6'h15;
    mon.relay_one = 1'b0;
    repeat (6) @(negedge clk);
    rd_chk(DMR_ADR_TERM_IO, 16'h0015);
    $display("test terminal done");
    bad(1'b0, 16'h2403);
    bad(1'b0, 16'h241f);
    bad(1'b0, 16'h242f);
    bad(1'b0, 16'h0000);
    bad(1'b1, 16'h2403);
    rd_chk(DMR_ADR_FREQ_REF, 16'h0001);
    $display("test range done");
    finish_test();
  end
endmodule
